// ==== verilog/szu_map.vh ====
`ifndef SZU_MAP_VH
`define SZU_MAP_VH
// register offsets on the local port
`define SZU_A_BUF 3'h0
`define SZU_A_CON 3'h1
`define SZU_A_CFG 3'h2
`define SZU_A_ADR 3'h3
`define SZU_A_ADM 3'h4
// serial_control_reg fields
`define SZU_C_SM0FE 7
`define SZU_C_SM1 6
`define SZU_C_SM2 5
`define SZU_C_REN 4
`define SZU_C_TB8 3
`define SZU_C_RB8 2
`define SZU_C_TI 1
`define SZU_C_RI 0
// serial_config_reg fields
`define SZU_G_M0X3 0
`define SZU_G_FESEL 1
`define SZU_G_M2FAST 2
`define SZU_G_SPI 3
`define SZU_G_CLKLAT 4
`define SZU_G_W 5
// reset values
`define SZU_CFG_RST 5'h10
`define SZU_ADR_RST 8'h00
`define SZU_ADM_RST 8'h00
`define SZU_TXSR_RST 11'h7ff
// sync mode half periods in system clocks (bit = 12 or 4 clocks)
`define SZU_M0_HALF_SLOW 3'h6
`define SZU_M0_HALF_FAST 3'h2
// async: 16 rate ticks per bit, sample in the middle
`define SZU_OVS_LAST 4'hf
`define SZU_OVS_MID 4'h7
// index of the last frame bit after the start bit
`define SZU_LAST_M1 4'h9
`define SZU_LAST_M23 4'ha
`endif

// ==== verilog/szu_uart.v ====
// Implementation choices: strobed register access and the register offsets.
`timescale 1ns/1ps
`include "szu_map.vh"

module szu_uart (
  input wire i_clk,
  input wire i_arst_n,
  input wire i_ce,
  input wire [2:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output wire [7:0] o_rdata,
  input wire i_tmr_ovf,
  input wire i_data_pin,
  input wire i_spi_miso,
  output wire o_data_pin,
  output wire o_data_pin_oe,
  output wire o_tx_clock_pin,
  output wire o_tx_done_flag,
  output wire o_rx_done_flag,
  output wire o_framing_error_flag
);

  localparam [1:0] TXS_IDLE = 2'b01;
  localparam [1:0] TXS_BUSY = 2'b10;
  localparam [2:0] RXS_IDLE = 3'b001;
  localparam [2:0] RXS_START = 3'b010;
  localparam [2:0] RXS_BITS = 3'b100;
  localparam [1:0] SHS_IDLE = 2'b01;
  localparam [1:0] SHS_RUN = 2'b10;

  function [3:0] szu_last;
    input [1:0] md;
    begin
      szu_last = (md == 2'd1) ? `SZU_LAST_M1 : `SZU_LAST_M23;
    end
  endfunction

  function szu_match;
    input [7:0] d;
    input [7:0] a;
    input [7:0] m;
    begin
      szu_match = (((d ^ a) & m) == 8'h00);
    end
  endfunction

  reg sm0_ff;
  reg sm1_ff;
  reg sm2_ff;
  reg ren_ff;
  reg tb8_ff;
  reg rb8_ff;
  reg ti_ff;
  reg ri_ff;
  reg fe_ff;
  reg [`SZU_G_W-1:0] cfg_ff;
  reg [7:0] adr_ff;
  reg [7:0] adm_ff;
  reg [7:0] rbuf_ff;
  reg [7:0] rdata_ff;
  reg [1:0] pre_ff;
  reg [1:0] tx_st_ff;
  reg [10:0] tx_sr_ff;
  reg [3:0] tx_tk_ff;
  reg [3:0] tx_bit_ff;
  reg [2:0] rx_st_ff;
  reg [9:0] rx_sr_ff;
  reg [3:0] rx_tk_ff;
  reg [3:0] rx_bit_ff;
  reg rxd_prev_ff;
  reg [1:0] sh_st_ff;
  reg sh_dir_ff;
  reg sh_ph_ff;
  reg [2:0] sh_div_ff;
  reg [2:0] sh_bit_ff;
  reg [7:0] sh_tx_ff;
  reg [7:0] sh_rx_ff;
  reg pin_d_ff;
  reg pin_oe_ff;
  reg pin_clk_ff;

  wire [1:0] mode = {sm0_ff, sm1_ff};
  wire is_sync = (mode == 2'd0);
  wire spi = cfg_ff[`SZU_G_SPI];
  wire fesel = cfg_ff[`SZU_G_FESEL];
  wire clk_idle = cfg_ff[`SZU_G_CLKLAT];
  wire buf_wr = i_wr & (i_addr == `SZU_A_BUF);
  wire con_wr = i_wr & (i_addr == `SZU_A_CON);
  wire cfg_wr = i_wr & (i_addr == `SZU_A_CFG);
  wire [3:0] last = szu_last(mode);

  // mode 2 prescaler: 16 ticks of 2 or 4 clocks give 1/32 or 1/64
  wire pre_hit = cfg_ff[`SZU_G_M2FAST] ? pre_ff[0] :
                 (pre_ff == 2'h3);
  // variable rate modes count timer overflow pulses
  wire tick = (mode == 2'd2) ? pre_hit : i_tmr_ovf;

  // async transmit timing
  wire tx_busy = (tx_st_ff == TXS_BUSY);
  wire tx_bit_end = tx_busy & tick & (tx_tk_ff == `SZU_OVS_LAST);
  wire tx_ti_set = tx_bit_end & (tx_bit_ff == last - 4'h1);

  // async receive: last sample completes the frame
  wire rx_mid = tick & (rx_tk_ff == `SZU_OVS_LAST);
  wire [9:0] rx_nx = {i_data_pin, rx_sr_ff[9:1]};
  wire rx_done = (rx_st_ff == RXS_BITS) & rx_mid &
                 (rx_bit_ff == last - 4'h1);
  wire m1 = (mode == 2'd1);
  wire [7:0] rx_byte = m1 ? rx_nx[8:1] : rx_nx[7:0];
  wire rx_b8 = m1 ? rx_nx[9] : rx_nx[8];
  wire rx_stop = rx_nx[9];
  // multiprocessor gating: modes 2 and 3 ignore data bytes and need an address match, mode 1 needs a valid stop bit
  wire rx_ok = ~sm2_ff | (m1 ? rx_stop :
               (rx_b8 & szu_match(rx_byte, adr_ff, adm_ff)));
  wire rx_take = rx_done & ~ri_ff & rx_ok;
  wire fe_set = rx_done & ~rx_stop;

  // sync / spi shift engine
  wire [2:0] half = cfg_ff[`SZU_G_M0X3] ? `SZU_M0_HALF_FAST :
                    `SZU_M0_HALF_SLOW;
  wire sh_run = (sh_st_ff == SHS_RUN);
  wire sh_half_end = sh_run & (sh_div_ff == half - 3'h1);
  wire sh_bit_end = sh_half_end & sh_ph_ff;
  wire sh_done = sh_bit_end & (sh_bit_ff == 3'h7);
  wire sh_sample = spi ? i_spi_miso : i_data_pin;
  wire sh_rx_on = ~sh_dir_ff | spi;
  wire sh_take = sh_done & sh_rx_on & ~ri_ff;
  wire sh_rx_start = ren_ff & ~ri_ff & ~spi;
  wire sh_go = is_sync & ~sh_run & (buf_wr | sh_rx_start);

  wire ti_set = tx_ti_set | (sh_done & (sh_dir_ff | spi));
  wire ri_set = rx_take | sh_take;

  // registers written by software
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sm0_ff <= 1'b0;
      sm1_ff <= 1'b0;
      sm2_ff <= 1'b0;
      ren_ff <= 1'b0;
      tb8_ff <= 1'b0;
      cfg_ff <= `SZU_CFG_RST;
      adr_ff <= `SZU_ADR_RST;
      adm_ff <= `SZU_ADM_RST;
    end else if (i_ce) begin
      if (con_wr) begin
        if (!fesel) begin
          sm0_ff <= i_wdata[`SZU_C_SM0FE];
        end
        sm1_ff <= i_wdata[`SZU_C_SM1];
        sm2_ff <= i_wdata[`SZU_C_SM2];
        ren_ff <= i_wdata[`SZU_C_REN];
        tb8_ff <= i_wdata[`SZU_C_TB8];
      end
      if (cfg_wr) begin
        cfg_ff <= i_wdata[`SZU_G_W-1:0];
      end
      if (i_wr && i_addr == `SZU_A_ADR) begin
        adr_ff <= i_wdata;
      end
      if (i_wr && i_addr == `SZU_A_ADM) begin
        adm_ff <= i_wdata;
      end
    end
  end

  // flags: a hardware set wins over a software write in the same cycle
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ti_ff <= 1'b0;
      ri_ff <= 1'b0;
      rb8_ff <= 1'b0;
      fe_ff <= 1'b0;
      rbuf_ff <= 8'h00;
    end else if (i_ce) begin
      ti_ff <= ti_set | (con_wr ? i_wdata[`SZU_C_TI] : ti_ff);
      ri_ff <= ri_set | (con_wr ? i_wdata[`SZU_C_RI] : ri_ff);
      // writing one to bit 7 leaves the error alone
      fe_ff <= fe_set | (fe_ff & ~(con_wr & fesel &
               ~i_wdata[`SZU_C_SM0FE]));
      if (rx_take) begin
        rbuf_ff <= rx_byte;
        rb8_ff <= rx_b8;
      end else if (sh_take) begin
        rbuf_ff <= {sh_sample, sh_rx_ff[7:1]};
      end else if (con_wr) begin
        rb8_ff <= i_wdata[`SZU_C_RB8];
      end
    end
  end

  // read port: data only in the cycle after the strobe
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rdata_ff <= 8'h00;
    end else if (i_ce) begin
      if (!i_rd) begin
        rdata_ff <= 8'h00;
      end else begin
        case (i_addr)
          `SZU_A_BUF: rdata_ff <= rbuf_ff;
          `SZU_A_CON: rdata_ff <= {(fesel ? fe_ff : sm0_ff),
                        sm1_ff, sm2_ff, ren_ff, tb8_ff, rb8_ff,
                        ti_ff, ri_ff};
          `SZU_A_CFG: rdata_ff <= {{(8-`SZU_G_W){1'b0}}, cfg_ff};
          `SZU_A_ADR: rdata_ff <= adr_ff;
          `SZU_A_ADM: rdata_ff <= adm_ff;
          default: rdata_ff <= 8'h00;
        endcase
      end
    end
  end

  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pre_ff <= 2'h0;
    end else if (i_ce) begin
      pre_ff <= pre_ff + 2'h1;
    end
  end

  // async transmitter, independent of the receiver
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      tx_st_ff <= TXS_IDLE;
      tx_sr_ff <= `SZU_TXSR_RST;
      tx_tk_ff <= 4'h0;
      tx_bit_ff <= 4'h0;
    end else if (i_ce) begin
      case (tx_st_ff)
        TXS_IDLE: begin
          // a write while a frame runs is dropped: no transmit queue
          if (buf_wr && !is_sync) begin
            // ninth slot holds stop in mode 1, tb8 otherwise
            tx_sr_ff <= {1'b1, (m1 | tb8_ff), i_wdata,
                         1'b0};
            tx_tk_ff <= 4'h0;
            tx_bit_ff <= 4'h0;
            tx_st_ff <= TXS_BUSY;
          end
        end
        TXS_BUSY: begin
          if (tick) begin
            tx_tk_ff <= tx_tk_ff + 4'h1;
          end
          if (tx_bit_end) begin
            tx_sr_ff <= {1'b1, tx_sr_ff[10:1]};
            tx_bit_ff <= tx_bit_ff + 4'h1;
            if (tx_bit_ff == last) begin
              tx_st_ff <= TXS_IDLE;
            end
          end
        end
        default: tx_st_ff <= TXS_IDLE;
      endcase
    end
  end

  // async receiver with 16x oversampling
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rx_st_ff <= RXS_IDLE;
      rx_sr_ff <= 10'h000;
      rx_tk_ff <= 4'h0;
      rx_bit_ff <= 4'h0;
      rxd_prev_ff <= 1'b1;
    end else if (i_ce) begin
      rxd_prev_ff <= i_data_pin;
      case (rx_st_ff)
        RXS_IDLE: begin
          if (!is_sync && ren_ff && rxd_prev_ff &&
              !i_data_pin) begin
            rx_tk_ff <= 4'h0;
            rx_st_ff <= RXS_START;
          end
        end
        RXS_START: begin
          if (tick) begin
            rx_tk_ff <= rx_tk_ff + 4'h1;
            if (rx_tk_ff == `SZU_OVS_MID) begin
              // a glitch shorter than half a bit is not a start
              if (i_data_pin) begin
                rx_st_ff <= RXS_IDLE;
              end else begin
                rx_tk_ff <= 4'h0;
                rx_bit_ff <= 4'h0;
                rx_st_ff <= RXS_BITS;
              end
            end
          end
        end
        RXS_BITS: begin
          if (tick) begin
            rx_tk_ff <= rx_tk_ff + 4'h1;
          end
          if (rx_mid) begin
            rx_sr_ff <= rx_nx;
            rx_bit_ff <= rx_bit_ff + 4'h1;
            if (rx_done) begin
              rx_st_ff <= RXS_IDLE;
            end
          end
        end
        default: rx_st_ff <= RXS_IDLE;
      endcase
    end
  end

  // sync mode 0 and spi master shift engine, half duplex on mode 0
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sh_st_ff <= SHS_IDLE;
      sh_dir_ff <= 1'b0;
      sh_ph_ff <= 1'b0;
      sh_div_ff <= 3'h0;
      sh_bit_ff <= 3'h0;
      sh_tx_ff <= 8'h00;
      sh_rx_ff <= 8'h00;
    end else if (i_ce) begin
      case (sh_st_ff)
        SHS_IDLE: begin
          if (sh_go) begin
            // transmit wins when both could start
            sh_dir_ff <= buf_wr;
            sh_tx_ff <= buf_wr ? i_wdata : 8'hff;
            sh_ph_ff <= 1'b0;
            sh_div_ff <= 3'h0;
            sh_bit_ff <= 3'h0;
            sh_st_ff <= SHS_RUN;
          end
        end
        SHS_RUN: begin
          sh_div_ff <= sh_half_end ? 3'h0 : sh_div_ff + 3'h1;
          if (sh_half_end) begin
            sh_ph_ff <= ~sh_ph_ff;
          end
          if (sh_bit_end) begin
            // sample as the clock leaves its idle level
            sh_rx_ff <= {sh_sample, sh_rx_ff[7:1]};
            sh_tx_ff <= {1'b1, sh_tx_ff[7:1]};
            sh_bit_ff <= sh_bit_ff + 3'h1;
            if (sh_done) begin
              sh_st_ff <= SHS_IDLE;
            end
          end
        end
        default: sh_st_ff <= SHS_IDLE;
      endcase
    end
  end

  // pins, registered; they lag the engine state by one clock
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pin_d_ff <= 1'b1;
      pin_oe_ff <= 1'b0;
      pin_clk_ff <= 1'b1;
    end else if (i_ce) begin
      if (is_sync) begin
        // active half first, back to idle for the second half
        pin_clk_ff <= sh_run ? (clk_idle ^ ~sh_ph_ff) :
                      clk_idle;
        pin_oe_ff <= sh_run & (sh_dir_ff | spi);
        pin_d_ff <= sh_run ? sh_tx_ff[0] : 1'b1;
      end else begin
        pin_clk_ff <= tx_sr_ff[0];
        pin_oe_ff <= 1'b0;
        pin_d_ff <= 1'b1;
      end
    end
  end

  assign o_rdata = rdata_ff;
  assign o_data_pin = pin_d_ff;
  assign o_data_pin_oe = pin_oe_ff;
  assign o_tx_clock_pin = pin_clk_ff;
  assign o_tx_done_flag = ti_ff;
  assign o_rx_done_flag = ri_ff;
  assign o_framing_error_flag = fe_ff;

endmodule

// ==== sim/szu_uart_asserts.sv ====
`timescale 1ns/1ps
`include "szu_map.vh"
module szu_uart_chk (
  input wire i_clk,
  input wire i_arst_n,
  input wire i_ce,
  input wire [2:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  input wire [7:0] o_rdata,
  input wire o_data_pin,
  input wire o_data_pin_oe,
  input wire o_tx_clock_pin,
  input wire o_framing_error_flag
);
  reg [4:0] cfg_ff;
  wire con_wr = i_ce && i_wr && i_addr == `SZU_A_CON;
  wire act = o_data_pin_oe && (o_tx_clock_pin != cfg_ff[4]);
  // config shadow: rate and idle level decide the sync timing
  always @(posedge i_clk or negedge i_arst_n)
    if (!i_arst_n)
      cfg_ff <= `SZU_CFG_RST;
    else if (i_ce && i_wr && i_addr == `SZU_A_CFG)
      cfg_ff <= i_wdata[4:0];
  default clocking dc @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  AST_RD_ZERO: assert property (
    i_ce && !i_rd |=> o_rdata == 8'h00)
    else $error("read data outside read cycle");
  AST_UNMAPPED: assert property (
    i_rd && i_addr > 3'h4 |=> o_rdata == 8'h00)
    else $error("unmapped read not zero");
  AST_CFG_RB: assert property (
    i_ce && i_rd && i_addr == `SZU_A_CFG |=> o_rdata[4:0] == $past(cfg_ff))
    else $error("config readback wrong");
  AST_DATA_HOLD: assert property (
    o_data_pin_oe && $changed(o_tx_clock_pin)
    && o_tx_clock_pin == cfg_ff[4] |-> $stable(o_data_pin))
    else $error("data moved at sampling edge");
  AST_HALF_FAST: assert property (
    act && cfg_ff[0] && $changed(o_tx_clock_pin)
    |=> $stable(o_tx_clock_pin) ##1 $changed(o_tx_clock_pin))
    else $error("fast half period wrong");
  AST_HALF_SLOW: assert property (
    act && !cfg_ff[0] && $changed(o_tx_clock_pin)
    |=> $stable(o_tx_clock_pin)[*5] ##1 $changed(o_tx_clock_pin))
    else $error("slow half period wrong");
  AST_FE_STICKY: assert property (
    $fell(o_framing_error_flag) |-> $past(con_wr) && $past(i_wdata) < 8'h80)
    else $error("framing error cleared by itself");
  AST_FE_CLEAR: assert property (
    con_wr && !i_wdata[7] && cfg_ff[1] |=> !o_framing_error_flag)
    else $error("framing error not cleared");
endmodule
bind szu_uart szu_uart_chk i_chk (
  .i_clk(i_clk), .i_arst_n(i_arst_n), .i_ce(i_ce), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .o_data_pin(o_data_pin), .o_data_pin_oe(o_data_pin_oe),
  .o_tx_clock_pin(o_tx_clock_pin),
  .o_framing_error_flag(o_framing_error_flag)
);

// ==== sim/szu_peer.sv ====
`timescale 1ns/1ps
module szu_peer (
  input wire i_clk,
  input wire i_tx,
  input wire i_mosi,
  output reg o_rxd,
  output reg o_miso
);
  reg [10:0] got;
  integer cyc;
  integer span;
  initial begin
    o_rxd = 1'b1;
    o_miso = 1'b1;
    cyc = 0;
  end
  always @(posedge i_clk)
    cyc <= cyc + 1;
  // wait while the dut line sits at lvl, bounded so a dead line returns
  task hold(input lvl);
    integer t;
    for (t = 0; t < 2000 && i_tx === lvl; t = t + 1)
      @(posedge i_clk);
  endtask
  // start, bits lsb first, stop, then one idle cell
  task send(input [10:0] frm, input integer n, input integer per);
    integer i;
    for (i = 0; i <= n; i = i + 1) begin
      o_rxd <= (i < n) ? frm[i] : 1'b1;
      repeat (per) @(posedge i_clk);
    end
  endtask
  // read each cell in its middle, so a wrong rate misreads
  task catch(input integer n, input integer per);
    integer i;
    got = 11'h0;
    hold(1'b1);
    repeat (per / 2) @(posedge i_clk);
    for (i = 0; i < n; i = i + 1) begin
      got[i] = i_tx;
      repeat (per) @(posedge i_clk);
    end
  endtask
  // new bit as the clock leaves idle, dut bit taken as it returns
  task sync(input [7:0] din, input idle);
    integer i;
    integer c0;
    c0 = 0;
    for (i = 0; i < 8; i = i + 1) begin
      hold(idle);
      o_rxd <= din[i];
      o_miso <= din[i];
      hold(~idle);
      got[i] = i_mosi;
      if (i == 0)
        c0 = cyc;
    end
    span = cyc - c0;
    // last bit is sampled at the end of its idle half, so keep it
    repeat (12) @(posedge i_clk);
    o_rxd <= ~din[7];
    o_miso <= ~din[7];
  endtask
endmodule

// ==== sim/szu_uart_tb.sv ====
`timescale 1ns/1ps
`include "szu_map.vh"
module szu_uart_tb;
  reg clk = 1'b0;
  reg arst_n = 1'b0;
  reg [2:0] addr = 3'h0;
  reg [7:0] wdata = 8'h00;
  reg wr = 1'b0;
  reg rd = 1'b0;
  reg tick = 1'b0;
  reg tick_en = 1'b0;
  reg [7:0] v;
  integer err_total = 0;
  integer n_checks = 0;
  wire [7:0] rdata;
  wire pin_out, pin_oe, sclk, ti, ri, fe, prx, pmiso;
  // shared data pin: the dut wins while it drives
  wire pin = pin_oe ? pin_out : prx;
  always #50 clk = ~clk;
  // one-cycle tick every second clock paces modes 1 and 3
  always @(posedge clk)
    tick <= tick_en & ~tick;
  szu_uart i_dut (
    .i_clk(clk), .i_arst_n(arst_n), .i_ce(1'b1), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
    .i_tmr_ovf(tick), .i_data_pin(pin), .i_spi_miso(pmiso),
    .o_data_pin(pin_out), .o_data_pin_oe(pin_oe), .o_tx_clock_pin(sclk),
    .o_tx_done_flag(ti), .o_rx_done_flag(ri), .o_framing_error_flag(fe)
  );
  szu_peer i_peer (
    .i_clk(clk), .i_tx(sclk), .i_mosi(pin_out), .o_rxd(prx), .o_miso(pmiso)
  );
  task chk(input string nm, input [10:0] e, input [10:0] g);
    n_checks = n_checks + 1;
    if (g !== e) begin
      err_total = err_total + 1;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  task wreg(input [2:0] a, input [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task rreg(input [2:0] a);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    v = rdata;
  endtask
  task wflag(input r);
    integer t;
    for (t = 0; t < 3000 && (r ? ri : ti) !== 1'b1; t = t + 1)
      @(posedge clk);
  endtask
  task t_reset;
    chk("line idle", 1, sclk);
    rreg(`SZU_A_CON);
    chk("control", 8'h00, v);
    rreg(`SZU_A_CFG);
    chk("config", `SZU_CFG_RST, v[4:0]);
    rreg(3'h5);
    chk("unmapped", 8'h00, v);
    $display("test reset done");
  endtask
  task t_m2(input fast, input tb8, input [7:0] d);
    wreg(`SZU_A_CFG, {5'h02, fast, 2'h0});
    wreg(`SZU_A_CON, {4'h8, tb8, 3'h0});
    fork
      i_peer.catch(11, fast ? 32 : 64);
      wreg(`SZU_A_BUF, d);
    join
    chk("mode 2 frame", {1'b1, tb8, d, 1'b0}, i_peer.got);
    wflag(0);
    chk("tx done", 1, ti);
    $display("test mode 2 done");
  endtask
  task t_m1;
    tick_en <= 1'b1;
    wreg(`SZU_A_CON, 8'h50);
    fork
      i_peer.send({2'h3, 8'h3c, 1'b0}, 10, 32);
      i_peer.catch(10, 32);
      wreg(`SZU_A_BUF, 8'hc3);
    join
    chk("mode 1 frame", {2'h1, 8'hc3, 1'b0}, i_peer.got);
    wflag(1);
    rreg(`SZU_A_CON);
    chk("control", 8'h57, v);
    rreg(`SZU_A_BUF);
    chk("rx byte", 8'h3c, v);
    $display("test mode 1 duplex done");
  endtask
  task t_m3;
    wreg(`SZU_A_CON, 8'hd0);
    wreg(`SZU_A_CFG, 8'h12);
    i_peer.send({2'h1, 8'h81, 1'b0}, 11, 32);
    chk("framing error", 1, fe);
    rreg(`SZU_A_CON);
    chk("control", 8'hd5, v);
    wreg(`SZU_A_CON, 8'h50);
    chk("error cleared", 0, fe);
    i_peer.send({2'h2, 8'h11, 1'b0}, 11, 32);
    fork
      i_peer.send({2'h2, 8'h22, 1'b0}, 11, 32);
      begin
        repeat (100) @(posedge clk);
        rreg(`SZU_A_BUF);
        wreg(`SZU_A_CON, 8'h50);
      end
    join
    chk("first byte", 8'h11, v);
    i_peer.send({2'h2, 8'h33, 1'b0}, 11, 32);
    rreg(`SZU_A_BUF);
    chk("held byte", 8'h22, v);
    $display("test mode 3 done");
  endtask
  task t_addr;
    wreg(`SZU_A_ADR, 8'h42);
    wreg(`SZU_A_ADM, 8'hff);
    wreg(`SZU_A_CON, 8'h70);
    rreg(`SZU_A_ADR);
    chk("address", 8'h42, v);
    // a data byte carrying the address value must still be ignored
    i_peer.send({2'h2, 8'h42, 1'b0}, 11, 32);
    chk("data ignored", 0, ri);
    i_peer.send({2'h3, 8'h24, 1'b0}, 11, 32);
    chk("other address", 0, ri);
    i_peer.send({2'h3, 8'h42, 1'b0}, 11, 32);
    chk("own address", 1, ri);
    rreg(`SZU_A_BUF);
    chk("address byte", 8'h42, v);
    rreg(`SZU_A_CON);
    chk("control", 8'h75, v);
    $display("test address recognition done");
  endtask
  task t_sync(input [7:0] cfg, input [7:0] d, input [7:0] din);
    wreg(`SZU_A_CFG, cfg);
    wreg(`SZU_A_CON, 8'h00);
    @(posedge clk);
    chk("clock idle", cfg[4], sclk);
    fork
      i_peer.sync(din, cfg[4]);
      wreg(`SZU_A_BUF, d);
    join
    chk("sync out", d, i_peer.got[7:0]);
    chk("span", cfg[0] ? 28 : 84, i_peer.span);
    wflag(0);
    chk("tx done", 1, ti);
    rreg(`SZU_A_BUF);
    chk("pin released", 0, pin_oe);
    if (cfg[3])
      chk("spi in", din, v);
    $display("test sync transmit done");
  endtask
  task t_srx;
    wreg(`SZU_A_CFG, 8'h11);
    // the clock pin takes its new idle level one clock after the write
    @(posedge clk);
    fork
      i_peer.sync(8'hb4, 1'b1);
      wreg(`SZU_A_CON, 8'h10);
    join
    wflag(1);
    chk("rx done", 1, ri);
    rreg(`SZU_A_BUF);
    chk("sync in", 8'hb4, v);
    $display("test sync receive done");
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    t_reset;
    t_m2(1'b1, 1'b1, 8'ha5);
    t_m2(1'b0, 1'b0, 8'h5a);
    t_m1;
    t_m3;
    t_addr;
    t_sync(8'h11, 8'h3c, 8'h5a);
    t_sync(8'h08, 8'hc6, 8'h93);
    t_srx;
    stop_test;
  end
  initial begin
    repeat (40000) @(posedge clk);
    err_total = err_total + 1;
    stop_test;
  end
endmodule
